// ---- core/pepc_pkg.sv ----
package pepc_pkg;

  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] REG_CTRL   = 12'h740;
  localparam logic [11:0] REG_STAT   = 12'h744;
  localparam logic [11:0] REG_REPCTL = 12'h748;
  localparam logic [11:0] REG_TALLY  = 12'h74c;

  // control, status and header field positions
  localparam int unsigned CTRL_DIS_BIT   = 0;
  localparam int unsigned CTRL_INJ_BIT   = 1;
  localparam int unsigned CTRL_LEN_LSB   = 8;
  localparam int unsigned CTRL_LEN_MSB   = 15;
  localparam int unsigned STAT_ERR_BIT   = 0;
  localparam int unsigned HDR_LEN_LSB    = 0;
  localparam int unsigned HDR_LEN_MSB    = 7;

  // reset values and tally limit
  localparam logic [7:0] LEN_RST    = 8'h00;
  localparam logic [1:0] REPORT_RST = 2'h2;
  localparam logic [7:0] TALLY_MAX  = 8'hff;
  localparam logic [7:0] TALLY_RST  = 8'h00;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    PEPC_REP_NONE     = 2'b00,
    PEPC_REP_COR      = 2'b01,
    PEPC_REP_NONFATAL = 2'b10,
    PEPC_REP_FATAL    = 2'b11
  } pepc_report_e;

  // one double word with its parity and packet framing
  typedef struct packed {
    logic              sop;
    logic              eop;
    logic              parity;
    logic [DATA_W-1:0] data;
  } pepc_dword_s;

  localparam int unsigned DWORD_W = DATA_W + 3;

endpackage : pepc_pkg

// ---- core/pepc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module pepc_fifo #(
  parameter int unsigned WIDTH = 35,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // pepc_fifo
`default_nettype wire

// ---- core/pepc_port.sv ----
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module pepc_port
  import pepc_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              sticky_rstn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [11:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [DATA_W-1:0] hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [DATA_W-1:0] hrdata,
  // egress toward the switch core (port generates parity)
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire logic              tx_sop,
  input  wire logic              tx_eop,
  input  wire logic [DATA_W-1:0] tx_data,
  output logic                   core_valid,
  input  wire logic              core_ready,
  output pepc_dword_s            core_dword,
  // ingress from the switch core (port checks parity)
  input  wire logic              rx_valid,
  input  wire pepc_dword_s       rx_dword,
  // error reporting message request
  output logic                   report_valid,
  output pepc_report_e           report_kind
);

  // sticky control and tally, only sticky_rstn resets them; flag and report_sel reset on hresetn
  logic         check_disable;
  logic         bad_parity_inject;
  logic [7:0]   match_length;
  logic         parity_error_flag;
  pepc_report_e report_sel;
  logic [7:0]   parity_error_tally;

  // ahb address phase capture
  logic         ap_valid;
  logic         ap_write;
  logic [11:0]  ap_addr;
  logic         ap_take;

  assign ap_take   = hsel && hready && htrans == HTRANS_NONSEQ;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= '0;
    end else if (hready) begin
      ap_valid <= ap_take;
      ap_write <= hwrite;
      ap_addr  <= haddr;
    end
  end

  logic wr_ctrl;
  logic wr_stat;
  logic wr_rep;
  logic rd_tally;
  assign wr_ctrl  = ap_valid && ap_write && ap_addr == REG_CTRL;
  assign wr_stat  = ap_valid && ap_write && ap_addr == REG_STAT;
  assign wr_rep   = ap_valid && ap_write && ap_addr == REG_REPCTL;
  assign rd_tally = ap_take && !hwrite && haddr == REG_TALLY;

  // read data registered at the address phase; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (ap_take && !hwrite) begin
      hrdata <= '0;
      case (haddr)
        REG_CTRL: begin
          hrdata[CTRL_DIS_BIT]                <= check_disable;
          hrdata[CTRL_INJ_BIT]                <= bad_parity_inject;
          hrdata[CTRL_LEN_MSB:CTRL_LEN_LSB]   <= match_length;
        end
        REG_STAT:   hrdata[STAT_ERR_BIT] <= parity_error_flag;
        REG_REPCTL: hrdata[1:0]          <= report_sel;
        REG_TALLY:  hrdata[7:0]          <= parity_error_tally;
        default:    hrdata <= '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge sticky_rstn) begin
    if (!sticky_rstn) begin
      check_disable     <= 1'b0;
      bad_parity_inject <= 1'b0;
      match_length      <= LEN_RST;
    end else if (wr_ctrl) begin
      check_disable     <= hwdata[CTRL_DIS_BIT];
      bad_parity_inject <= hwdata[CTRL_INJ_BIT];
      match_length      <= hwdata[CTRL_LEN_MSB:CTRL_LEN_LSB];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      report_sel <= pepc_report_e'(REPORT_RST);
    end else if (wr_rep) begin
      report_sel <= pepc_report_e'(hwdata[1:0]);
    end
  end

  // ingress parity check
  logic parity_err;
  assign parity_err = rx_valid && !check_disable && ((^rx_dword.data) != rx_dword.parity);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      parity_error_flag <= 1'b0;
    end else if (parity_err) begin
      parity_error_flag <= 1'b1;
    end else if (wr_stat && hwdata[STAT_ERR_BIT]) begin
      parity_error_flag <= 1'b0;
    end
  end

  // saturating tally; an error in the read cycle survives as one
  always_ff @(posedge hclk or negedge sticky_rstn) begin
    if (!sticky_rstn) begin
      parity_error_tally <= TALLY_RST;
    end else if (rd_tally) begin
      parity_error_tally <= parity_err ? 8'h01 : TALLY_RST;
    end else if (parity_err && parity_error_tally != TALLY_MAX) begin
      parity_error_tally <= parity_error_tally + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      report_valid <= 1'b0;
      report_kind  <= PEPC_REP_NONE;
    end else begin
      report_valid <= parity_err && !parity_error_flag && report_sel != PEPC_REP_NONE;
      report_kind  <= report_sel;
    end
  end

  // egress: per-packet match latched at start of packet
  logic in_pkt_match;
  logic cur_match;
  logic fifo_in_ready;
  pepc_dword_s gen_dword;

  assign cur_match = bad_parity_inject &&
    (tx_sop ? (tx_data[HDR_LEN_MSB:HDR_LEN_LSB] == match_length) : in_pkt_match);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_pkt_match <= 1'b0;
    end else if (tx_valid && fifo_in_ready && tx_sop) begin
      in_pkt_match <= tx_data[HDR_LEN_MSB:HDR_LEN_LSB] == match_length;
    end
  end

  always_comb begin
    gen_dword.sop    = tx_sop;
    gen_dword.eop    = tx_eop;
    gen_dword.data   = tx_data;
    gen_dword.parity = (^tx_data) ^ cur_match;
  end

  assign tx_ready = fifo_in_ready;

  logic [DWORD_W-1:0] fifo_out;
  pepc_fifo #(
    .WIDTH (DWORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (tx_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (gen_dword),
    .out_valid (core_valid),
    .out_ready (core_ready),
    .out_data  (fifo_out)
  );
  assign core_dword = pepc_dword_s'(fifo_out);

  // checks
  property p_no_err_when_disabled;
    @(posedge hclk) disable iff (!hresetn)
      check_disable |=> !$rose(parity_error_flag);
  endproperty
  a_no_err_when_disabled: assert property (p_no_err_when_disabled)
    else $error("flag rose while checking disabled");

  property p_gen_parity;
    @(posedge hclk) disable iff (!hresetn)
      tx_valid && tx_ready && !cur_match |-> gen_dword.parity == ^tx_data;
  endproperty
  a_gen_parity: assert property (p_gen_parity)
    else $error("generated parity wrong");

  property p_inject;
    @(posedge hclk) disable iff (!hresetn)
      tx_valid && bad_parity_inject && tx_sop &&
        tx_data[HDR_LEN_MSB:HDR_LEN_LSB] == match_length
        |-> gen_dword.parity != ^tx_data;
  endproperty
  a_inject: assert property (p_inject)
    else $error("bad parity not injected");

  property p_set_flag;
    @(posedge hclk) disable iff (!hresetn)
      parity_err |=> parity_error_flag;
  endproperty
  a_set_flag: assert property (p_set_flag)
    else $error("error flag not set");

  property p_hold_flag;
    @(posedge hclk) disable iff (!hresetn)
      parity_error_flag && !(wr_stat && hwdata[STAT_ERR_BIT]) |=> parity_error_flag;
  endproperty
  a_hold_flag: assert property (p_hold_flag)
    else $error("error flag lost without clear");

  sequence s_rise;
    !parity_error_flag && parity_err && report_sel != PEPC_REP_NONE;
  endsequence
  property p_report;
    @(posedge hclk) disable iff (!hresetn)
      s_rise |=> report_valid && report_kind == $past(report_sel);
  endproperty
  a_report: assert property (p_report)
    else $error("report missing on rising flag");

  property p_tally_sat;
    @(posedge hclk) disable iff (!sticky_rstn)
      parity_error_tally == TALLY_MAX && !rd_tally |=> parity_error_tally == TALLY_MAX;
  endproperty
  a_tally_sat: assert property (p_tally_sat)
    else $error("tally wrapped");

  property p_tally_clr;
    @(posedge hclk) disable iff (!sticky_rstn)
      rd_tally && !parity_err |=> parity_error_tally == TALLY_RST;
  endproperty
  a_tally_clr: assert property (p_tally_clr)
    else $error("tally not cleared on read");

  property p_no_tally_when_disabled;
    @(posedge hclk) disable iff (!sticky_rstn)
      check_disable && !rd_tally |=> $stable(parity_error_tally);
  endproperty
  a_no_tally_when_disabled: assert property (p_no_tally_when_disabled)
    else $error("tally moved while checking disabled");

  property p_no_spurious_flag;
    @(posedge hclk) disable iff (!hresetn)
      !parity_error_flag && !parity_err |=> !parity_error_flag;
  endproperty
  a_no_spurious_flag: assert property (p_no_spurious_flag)
    else $error("error flag rose without an error");

  property p_clear_flag;
    @(posedge hclk) disable iff (!hresetn)
      wr_stat && hwdata[STAT_ERR_BIT] && !parity_err |=> !parity_error_flag;
  endproperty
  a_clear_flag: assert property (p_clear_flag)
    else $error("error flag not cleared by write one");

  property p_sticky_keep;
    @(posedge hclk) disable iff (!sticky_rstn)
      !wr_ctrl |=> $stable(match_length) && $stable(check_disable)
        && $stable(bad_parity_inject);
  endproperty
  a_sticky_keep: assert property (p_sticky_keep)
    else $error("sticky control changed without a write");

  // a pulse only on the zero to one step of the flag
  sequence s_no_rise;
    !(parity_err && !parity_error_flag);
  endsequence
  property p_report_quiet;
    @(posedge hclk) disable iff (!hresetn)
      s_no_rise |=> !report_valid;
  endproperty
  a_report_quiet: assert property (p_report_quiet)
    else $error("report without a rising flag");

  property p_tally_inc;
    @(posedge hclk) disable iff (!sticky_rstn)
      parity_err && !rd_tally && parity_error_tally != TALLY_MAX
        |=> parity_error_tally == $past(parity_error_tally) + 8'h01;
  endproperty
  a_tally_inc: assert property (p_tally_inc)
    else $error("tally did not count an error");

endmodule // pepc_port
`default_nettype wire

// ---- testbench/pepc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pepc_core_model
  import pepc_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              stall,
  input  wire logic              send,
  input  wire logic              bad,
  input  wire logic [DATA_W-1:0] word,
  output logic                   core_ready,
  output logic                   rx_valid,
  output pepc_dword_s            rx_dword
);
  logic [DATA_W-1:0] last_q;
  assign core_ready = ~stall;
  assign rx_valid   = send;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) last_q <= '0;
    else if (send) last_q <= word;
  end
  // idle lines show junk so stale data can never pass
  always_comb begin
    rx_dword.sop    = send;
    rx_dword.eop    = send;
    rx_dword.data   = send ? word : ~last_q;
    rx_dword.parity = send ? (^word) ^ bad : ~(^last_q);
  end
endmodule // pepc_core_model
`default_nettype wire

// ---- testbench/port_end_to_end_parity_check_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module port_end_to_end_parity_check_bench;
  import pepc_pkg::*;
  logic         hclk = 0, hresetn = 0, sticky_rstn = 0, hsel = 0, hwrite = 0;
  logic         tx_valid = 0, tx_sop = 0, tx_eop = 0, stall = 0, send = 0, bad = 0;
  logic         hreadyout, hresp, tx_ready, core_valid, core_ready, rx_valid, report_valid;
  logic         rs_en = 0;
  logic [11:0]  haddr = '0;
  logic [1:0]   htrans = '0;
  logic [31:0]  hwdata = '0, tx_data = '0, word = '0, hrdata, rd, seed = 32'h58;
  pepc_dword_s  core_dword, rx_dword;
  pepc_report_e report_kind;
  pepc_dword_s  dq[$];
  logic [1:0]   rq[$];
  int           bad_count = 0, n_tests = 0, cyc = 0;

  pepc_port i_dut(.hclk, .hresetn, .sticky_rstn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tx_valid,
    .tx_ready, .tx_sop, .tx_eop, .tx_data, .core_valid, .core_ready, .core_dword,
    .rx_valid, .rx_dword, .report_valid, .report_kind);
  pepc_core_model i_core(.hclk, .hresetn, .stall, .send, .bad, .word, .core_ready,
    .rx_valid, .rx_dword);

  always #10 hclk = ~hclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic miss(logic [34:0] g, logic [34:0] e);
    bad_count++;
    $display("unexpected at %0t: got %h expected %h", $time, g, e);
  endtask
  task automatic cmp_reg(logic [31:0] g, logic [31:0] e);
    n_tests++;
    if (g !== e) miss(g, e);
  endtask
  task automatic cmp_dw(pepc_dword_s g, pepc_dword_s e);
    n_tests++;
    if (g !== e) miss(g, e);
  endtask
  task automatic cmp_rep(logic [1:0] g, logic [1:0] e);
    n_tests++;
    if (g !== e) miss(g, e);
  endtask

  task automatic ahb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rchk(logic [11:0] a, logic [31:0] e);
    ahb(0, a, 32'h0);
    cmp_reg(rd, e);
  endtask

  // caller lowers tx_valid, so packets can run back to back
  task automatic pkt(logic [7:0] len, int n, logic inj);
    pepc_dword_s e;
    for (int i = 0; i < n; i++) begin
      e.sop = (i == 0);
      e.eop = (i == n - 1);
      e.data = rnd();
      if (i == 0) e.data[7:0] = len;
      e.parity = (^e.data) ^ inj;
      dq.push_back(e);
      tx_valid <= 1;
      tx_sop <= e.sop;
      tx_eop <= e.eop;
      tx_data <= e.data;
      @(posedge hclk);
      while (tx_ready !== 1'b1) @(posedge hclk);
    end
  endtask

  task automatic rxw(logic b);
    send <= 1;
    bad <= b;
    word <= rnd();
    @(posedge hclk);
    send <= 0;
    repeat (3) @(posedge hclk);
  endtask

  always @(posedge hclk) begin
    if (hresetn && core_valid === 1'b1 && core_ready === 1'b1) begin
      if (dq.size() == 0) miss(core_dword, '0);
      else cmp_dw(core_dword, dq.pop_front());
    end
    if (report_valid === 1'b1) begin
      if (rq.size() == 0) miss(report_kind, '0);
      else cmp_rep(report_kind, rq.pop_front());
    end
  end

  // whole run needs about 500 cycles
  always @(posedge hclk) begin
    cyc++;
    if (rs_en) stall <= ^rnd();
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    sticky_rstn <= 1;
    rchk(REG_CTRL, 32'h0);
    rchk(REG_STAT, 32'h0);
    rchk(REG_REPCTL, 32'h2);
    rchk(REG_TALLY, 32'h0);
    rchk(12'h7f0, 32'h0);
    ahb(1, REG_CTRL, 32'hffff_05fe);
    rchk(REG_CTRL, 32'h0502);
    rs_en <= 1;
    pkt(8'h05, 3, 1);
    pkt(8'h06, 2, 0);
    pkt(8'h05, 1, 1);
    tx_valid <= 0;
    ahb(1, REG_CTRL, 32'h0500);
    pkt(8'h05, 2, 0);
    tx_valid <= 0;
    ahb(1, REG_CTRL, 32'h0002);
    pkt(8'h00, 2, 1);
    pkt(8'hff, 1, 0);
    tx_valid <= 0;
    rs_en <= 0;
    @(posedge hclk);
    stall <= 1;
    fork
      begin
        pkt(8'h09, 12, 0);
        tx_valid <= 0;
      end
      begin
        repeat (20) @(posedge hclk);
        cmp_reg(tx_ready, 0);
        stall <= 0;
      end
    join
    while (dq.size() != 0) @(posedge hclk);
    @(posedge hclk);
    cmp_reg(core_valid, 0);
    rxw(0);
    rchk(REG_STAT, 32'h0);
    rq.push_back(2'h2);
    rxw(1);
    rxw(1);
    rchk(REG_STAT, 32'h1);
    ahb(1, REG_STAT, 32'h0);
    rchk(REG_STAT, 32'h1);
    ahb(1, REG_STAT, 32'h1);
    rchk(REG_STAT, 32'h0);
    rchk(REG_TALLY, 32'h2);
    rchk(REG_TALLY, 32'h0);
    for (int k = 0; k < 4; k++) begin
      ahb(1, REG_REPCTL, k);
      if (k != 0) rq.push_back(2'(k));
      rxw(1);
      ahb(1, REG_STAT, 32'h1);
    end
    rchk(REG_TALLY, 32'h4);
    ahb(1, REG_CTRL, 32'h1);
    rxw(1);
    rchk(REG_STAT, 32'h0);
    rchk(REG_TALLY, 32'h0);
    ahb(1, REG_CTRL, 32'h0);
    ahb(1, REG_REPCTL, 32'h0);
    send <= 1;
    bad <= 1;
    repeat (260) @(posedge hclk);
    send <= 0;
    repeat (3) @(posedge hclk);
    rchk(REG_TALLY, 32'hff);
    rchk(REG_TALLY, 32'h0);
    ahb(1, REG_STAT, 32'h1);
    ahb(1, REG_CTRL, 32'h0302);
    rxw(1);
    hresetn <= 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    rchk(REG_CTRL, 32'h0302);
    rchk(REG_TALLY, 32'h1);
    rchk(REG_STAT, 32'h0);
    rchk(REG_REPCTL, 32'h2);
    cmp_reg(rq.size(), 32'h0);
    cmp_reg(dq.size(), 32'h0);
    give_verdict();
  end
endmodule // port_end_to_end_parity_check_bench
`default_nettype wire
